/* logic/ldx_core.sv */
// Execution unit for stack, pair load, bank exchange and block move opcodes
// Operation
// - Push high byte first; pop high last
// - Push predecrements stack; pop postincrements stack
// - Two operand bytes follow opcode, low first
// - Opcode 11: first byte E, second D
// - Opcode 08 swaps acc/flag with alternate
// - Opcode D9 swaps three general pairs
// - Both swaps are single byte, no operand
// - Move up: copy, bump pointers, decrement counter
// - Repeat form loops until counter is zero
// - Down forms decrement both pointers instead
// - Full 16-bit pointers, overlap unrestricted
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------------------
// Two-entry request buffer
// ------------------------------------------------------------------------
module ldx_buffer
	import ldx_pkg::*;
#(
	parameter int W     = REQ_W, // Entry width
	parameter int DEPTH = 2      // Entry count
) (
	// Clock and reset
	input  wire logic         core_clk,
	input  wire logic         rst,
	// Filling side
	input  wire logic         in_valid,
	input  wire logic [W-1:0] in_data,
	output logic              in_ready,
	// Draining side
	output logic              out_valid,
	output logic [W-1:0]      out_data,
	input  wire logic         out_ready
);
	localparam int CW = $clog2(DEPTH + 1); // Fill count width

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] ent;   // Entry 0 is the head
		logic [CW-1:0]           cnt;   // Entries held
		logic                    valid; // Head is valid
	} ldx_buf_st_t;

	ldx_buf_st_t s_r;   // Buffer state
	ldx_buf_st_t s_nxt; // Next buffer state
	logic        push;  // Word accepted
	logic        pop;   // Word delivered
	logic [CW-1:0] widx; // Slot for incoming word

	assign in_ready  = (s_r.cnt != CW'(DEPTH)); // Full refuses new words
	assign out_valid = s_r.valid;
	assign out_data  = s_r.ent[0];

	// Shift on pop, append on push
	always_comb begin
		s_nxt = s_r;
		push  = in_valid && in_ready;
		pop   = s_r.valid && out_ready;
		widx  = s_r.cnt - CW'(pop);
		if (pop) begin
			for (int i = 0; i < DEPTH - 1; i++) begin
				s_nxt.ent[i] = s_r.ent[i + 1];
			end
		end
		if (push) begin
			s_nxt.ent[widx] = in_data;
		end
		s_nxt.cnt   = s_r.cnt + CW'(push) - CW'(pop);
		s_nxt.valid = (s_nxt.cnt != '0);
	end

	// State register
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end
endmodule

// ------------------------------------------------------------------------
// Execution core
// ------------------------------------------------------------------------
module ldx_core
	import ldx_pkg::*;
(
	// Clock and reset
	input  wire logic          core_clk,
	input  wire logic          rst,
	// Memory request
	output logic               mem_req_valid,
	output ldx_mem_req_t       mem_req,
	input  wire logic          mem_req_ready,
	// Memory read answer
	input  wire logic          mem_rsp_valid,
	input  wire logic [7:0]    mem_rsp_data,
	// Status
	output ldx_regs_t          regs,
	output logic               retire
);
	// Whole core state
	typedef struct packed {
		ldx_state_t        st;     // Sequencer state
		ldx_regs_t         r;      // Register file
		logic [7:0]        op;     // Current opcode
		logic [7:0]        lo;     // Low byte held between accesses
		logic              wait_r; // Read accepted, answer pending
		logic              retire; // Instruction done pulse
	} ldx_core_st_t;

	ldx_core_st_t s_r;   // Core state
	ldx_core_st_t s_nxt; // Next core state
	logic         req_v; // Request to buffer
	ldx_mem_req_t req_d; // Request contents
	logic         req_rdy; // Buffer has room
	logic [REQ_W-1:0] buf_out; // Buffer head

	// ----------------------------------------------------------------
	// Request buffer, stall of memory back-pressures the sequencer
	// ----------------------------------------------------------------
	ldx_buffer #(.W(REQ_W), .DEPTH(2)) u_buf (
		.core_clk  (core_clk),
		.rst       (rst),
		.in_valid  (req_v),
		.in_data   (req_d),
		.in_ready  (req_rdy),
		.out_valid (mem_req_valid),
		.out_data  (buf_out),
		.out_ready (mem_req_ready)
	);
	assign mem_req = ldx_mem_req_t'(buf_out);
	assign regs    = s_r.r;
	assign retire  = s_r.retire;

	// Read a pair by code; code 3 is acc/flag for stack ops, else sp
	function automatic logic [15:0] pair_get(ldx_regs_t r, logic [1:0] c, logic stk);
		case (c)
			PAIR_COUNTER: pair_get = r.bc;
			PAIR_DEST:    pair_get = r.de;
			PAIR_SOURCE:  pair_get = r.hl;
			default:      pair_get = stk ? r.af : r.sp;
		endcase
	endfunction

	// Write a pair by code
	function automatic ldx_regs_t pair_set(ldx_regs_t r, logic [1:0] c, logic stk,
		logic [15:0] v);
		ldx_regs_t t;
		t = r;
		case (c)
			PAIR_COUNTER: t.bc = v;
			PAIR_DEST:    t.de = v;
			PAIR_SOURCE:  t.hl = v;
			default: begin
				if (stk) begin
					t.af = v;
				end else begin
					t.sp = v;
				end
			end
		endcase
		pair_set = t;
	endfunction

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	always_comb begin
		logic [1:0]  pc_sel; // Pair field of opcode
		logic [15:0] pv;     // Selected pair value
		logic        down;   // Block move runs downward
		logic        rpt;    // Block move repeats
		logic [15:0] cnt;    // Counter after decrement
		pc_sel = s_r.op[PAIR_MSB:PAIR_LSB];
		pv     = pair_get(s_r.r, pc_sel, 1'b1);
		down   = (s_r.op == OP_MOVE_DN_ONCE) || (s_r.op == OP_MOVE_DN_RPT);
		rpt    = (s_r.op == OP_MOVE_UP_RPT) || (s_r.op == OP_MOVE_DN_RPT);
		cnt    = s_r.r.bc - PTR_STEP;
		s_nxt  = s_r;
		s_nxt.retire = 1'b0;
		req_v  = 1'b0;
		req_d  = '0;
		case (s_r.st)
			// Opcode fetch and dispatch
			ST_FETCH, ST_EXT_FETCH: begin
				if (!s_r.wait_r) begin
					req_v      = 1'b1;
					req_d.addr = s_r.r.pc;
					s_nxt.wait_r = req_rdy;
				end else if (mem_rsp_valid) begin
					s_nxt.wait_r = 1'b0;
					s_nxt.op     = mem_rsp_data;
					s_nxt.r.pc   = s_r.r.pc + PTR_STEP;
					s_nxt.retire = 1'b1; // Default: single byte done
					s_nxt.st     = ST_FETCH;
					if (s_r.st == ST_EXT_FETCH) begin
						// Block moves after prefix
						if ((mem_rsp_data == OP_MOVE_UP_ONCE) || (mem_rsp_data == OP_MOVE_UP_RPT)
							|| (mem_rsp_data == OP_MOVE_DN_ONCE)
							|| (mem_rsp_data == OP_MOVE_DN_RPT)) begin
							s_nxt.retire = 1'b0;
							s_nxt.st     = ST_MOVE_RD;
						end
					end else if (mem_rsp_data == OP_SWAP_ACC_FLAG) begin
						s_nxt.r.af     = s_r.r.af_alt;
						s_nxt.r.af_alt = s_r.r.af;
					end else if (mem_rsp_data == OP_SWAP_GENERAL) begin
						s_nxt.r.bc     = s_r.r.bc_alt;
						s_nxt.r.de     = s_r.r.de_alt;
						s_nxt.r.hl     = s_r.r.hl_alt;
						s_nxt.r.bc_alt = s_r.r.bc;
						s_nxt.r.de_alt = s_r.r.de;
						s_nxt.r.hl_alt = s_r.r.hl;
					end else if (mem_rsp_data == OP_PREFIX_EXT) begin
						s_nxt.retire = 1'b0;
						s_nxt.st     = ST_EXT_FETCH;
					end else if ((mem_rsp_data & OP_LOAD_PAIR_M) == OP_LOAD_PAIR_V) begin
						s_nxt.retire = 1'b0;
						s_nxt.st     = ST_IMM_LO;
					end else if ((mem_rsp_data & OP_PUSH_M) == OP_PUSH_V) begin
						s_nxt.retire = 1'b0;
						s_nxt.st     = ST_PUSH_HI;
					end else if ((mem_rsp_data & OP_POP_M) == OP_POP_V) begin
						s_nxt.retire = 1'b0;
						s_nxt.st     = ST_POP_LO;
					end
				end
			end
			// Immediate operand, low byte first
			ST_IMM_LO, ST_IMM_HI: begin
				if (!s_r.wait_r) begin
					req_v      = 1'b1;
					req_d.addr = s_r.r.pc;
					s_nxt.wait_r = req_rdy;
				end else if (mem_rsp_valid) begin
					s_nxt.wait_r = 1'b0;
					s_nxt.r.pc   = s_r.r.pc + PTR_STEP;
					if (s_r.st == ST_IMM_LO) begin
						s_nxt.lo = mem_rsp_data; // first byte low
						s_nxt.st = ST_IMM_HI;
					end else begin
						s_nxt.r  = pair_set(s_nxt.r, pc_sel, 1'b0, {mem_rsp_data, s_r.lo});
						s_nxt.retire = 1'b1;
						s_nxt.st = ST_FETCH;
					end
				end
			end
			// Push: predecrement, high byte then low byte
			ST_PUSH_HI, ST_PUSH_LO: begin
				req_v       = 1'b1;
				req_d.write = 1'b1;
				req_d.addr  = s_r.r.sp - PTR_STEP;
				req_d.wdata = (s_r.st == ST_PUSH_HI) ? pv[15:8] : pv[7:0];
				if (req_rdy) begin
					s_nxt.r.sp = s_r.r.sp - PTR_STEP;
					s_nxt.st   = (s_r.st == ST_PUSH_HI) ? ST_PUSH_LO : ST_FETCH;
					s_nxt.retire = (s_r.st == ST_PUSH_LO);
				end
			end
			// Pop: low byte then high byte, postincrement
			ST_POP_LO, ST_POP_HI: begin
				if (!s_r.wait_r) begin
					req_v      = 1'b1;
					req_d.addr = s_r.r.sp;
					s_nxt.wait_r = req_rdy;
				end else if (mem_rsp_valid) begin
					s_nxt.wait_r = 1'b0;
					s_nxt.r.sp   = s_r.r.sp + PTR_STEP;
					if (s_r.st == ST_POP_LO) begin
						s_nxt.lo = mem_rsp_data;
						s_nxt.st = ST_POP_HI;
					end else begin
						s_nxt.r  = pair_set(s_nxt.r, pc_sel, 1'b1, {mem_rsp_data, s_r.lo});
						s_nxt.retire = 1'b1;
						s_nxt.st = ST_FETCH;
					end
				end
			end
			// Block move: read source byte
			ST_MOVE_RD: begin
				if (!s_r.wait_r) begin
					req_v      = 1'b1;
					req_d.addr = s_r.r.hl;
					s_nxt.wait_r = req_rdy;
				end else if (mem_rsp_valid) begin
					s_nxt.wait_r = 1'b0;
					s_nxt.lo     = mem_rsp_data;
					s_nxt.st     = ST_MOVE_WR;
				end
			end
			// Block move: write destination, step pointers and counter
			ST_MOVE_WR: begin
				req_v       = 1'b1;
				req_d.write = 1'b1;
				req_d.addr  = s_r.r.de;
				req_d.wdata = s_r.lo;
				if (req_rdy) begin
					s_nxt.r.hl = down ? s_r.r.hl - PTR_STEP : s_r.r.hl + PTR_STEP;
					s_nxt.r.de = down ? s_r.r.de - PTR_STEP : s_r.r.de + PTR_STEP;
					s_nxt.r.bc = cnt;
					if (rpt && (cnt != CNT_ZERO)) begin
						s_nxt.st = ST_MOVE_RD; // test after decrement
					end else begin
						s_nxt.retire = 1'b1;
						s_nxt.st     = ST_FETCH;
					end
				end
			end
			default: begin
				s_nxt.st = ST_FETCH;
			end
		endcase
	end

	// State register
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			s_r        <= '0;
			s_r.st     <= ST_FETCH;
			s_r.r.pc   <= RST_PC;
			s_r.r.sp   <= RST_SP;
			s_r.r.af   <= RST_PAIR;
		end else begin
			s_r <= s_nxt;
		end
	end
endmodule

`default_nettype wire

/* logic/ldx_pkg.sv */
// Package for the load, exchange and block move execution unit
package ldx_pkg;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int BYTE_W = 8;  // Data byte width
	localparam int WORD_W = 16; // Pair, pointer and address width

	// ----------------------------------------------------------------
	// Opcodes handled by this unit
	// ----------------------------------------------------------------
	localparam logic [7:0] OP_SWAP_ACC_FLAG = 8'h08; // Swap acc/flag pair
	localparam logic [7:0] OP_SWAP_GENERAL  = 8'hd9; // Swap general bank
	localparam logic [7:0] OP_PREFIX_EXT    = 8'hed; // Extended prefix
	localparam logic [7:0] OP_MOVE_UP_ONCE  = 8'ha0; // block_move_up_once
	localparam logic [7:0] OP_MOVE_UP_RPT   = 8'hb0; // block_move_up_repeat
	localparam logic [7:0] OP_MOVE_DN_ONCE  = 8'ha8; // block_move_down_once
	localparam logic [7:0] OP_MOVE_DN_RPT   = 8'hb8; // block_move_down_repeat
	localparam logic [7:0] OP_LOAD_PAIR_M   = 8'hcf; // Mask: 01/11/21/31
	localparam logic [7:0] OP_LOAD_PAIR_V   = 8'h01; // Load pair immediate
	localparam logic [7:0] OP_PUSH_M        = 8'hcf; // Mask: c5/d5/e5/f5
	localparam logic [7:0] OP_PUSH_V        = 8'hc5; // Push pair
	localparam logic [7:0] OP_POP_M         = 8'hcf; // Mask: c1/d1/e1/f1
	localparam logic [7:0] OP_POP_V         = 8'hc1; // Pop pair

	// ----------------------------------------------------------------
	// Opcode fields and pair codes
	// ----------------------------------------------------------------
	localparam int PAIR_MSB = 5; // Pair select field, high bit
	localparam int PAIR_LSB = 4; // Pair select field, low bit
	localparam logic [1:0] PAIR_COUNTER = 2'h0; // byte_counter_pair
	localparam logic [1:0] PAIR_DEST    = 2'h1; // destination_pointer_pair
	localparam logic [1:0] PAIR_SOURCE  = 2'h2; // source_pointer_pair
	localparam logic [1:0] PAIR_LAST    = 2'h3; // stack_pointer or acc/flag

	// ----------------------------------------------------------------
	// Reset values and steps
	// ----------------------------------------------------------------
	localparam logic [15:0] RST_PC    = 16'h0000; // First fetch address
	localparam logic [15:0] RST_SP    = 16'hffff; // Stack pointer at reset
	localparam logic [15:0] RST_PAIR  = 16'h0000; // All other pairs
	localparam logic [15:0] PTR_STEP  = 16'h0001; // Pointer/counter step
	localparam logic [15:0] CNT_ZERO  = 16'h0000; // Counter exhausted

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_FETCH, ST_EXT_FETCH, ST_IMM_LO, ST_IMM_HI,
		ST_PUSH_HI, ST_PUSH_LO, ST_POP_LO, ST_POP_HI,
		ST_MOVE_RD, ST_MOVE_WR
	} ldx_state_t;

	// Memory request toward code, stack and data store
	typedef struct packed {
		logic [WORD_W-1:0] addr;  // Byte address
		logic [BYTE_W-1:0] wdata; // Write data
		logic              write; // 1 write, 0 read
	} ldx_mem_req_t;

	// Visible processor register view
	typedef struct packed {
		logic [WORD_W-1:0] pc;
		logic [WORD_W-1:0] sp;
		logic [WORD_W-1:0] af;
		logic [WORD_W-1:0] bc;
		logic [WORD_W-1:0] de;
		logic [WORD_W-1:0] hl;
		logic [WORD_W-1:0] af_alt;
		logic [WORD_W-1:0] bc_alt;
		logic [WORD_W-1:0] de_alt;
		logic [WORD_W-1:0] hl_alt;
	} ldx_regs_t;

	localparam int REQ_W = $bits(ldx_mem_req_t); // Buffered request width

endpackage

/* tb/ldx_core_assertions.sv */
// Checker on the execution unit's ports: memory channel, swaps, retire pulse
`timescale 1ns/1ps
`default_nettype none
module ldx_core_chk
	import ldx_pkg::*;
(
	// Clock and reset
	input wire logic         core_clk,
	input wire logic         rst,
	// Memory channel
	input wire logic         mem_req_valid,
	input wire ldx_mem_req_t mem_req,
	input wire logic         mem_req_ready,
	input wire logic         mem_rsp_valid,
	input wire logic [7:0]   mem_rsp_data,
	// Status
	input wire ldx_regs_t    regs,
	input wire logic         retire
);
	// ----------------------------------------------------------------
	// Helper state
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);
	logic        wr_prev_r; // Last taken request was a write
	logic [15:0] wa_prev_r; // Address of that request
	logic        rd_out_r;  // Read taken, answer pending

	// Track taken requests and open reads
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			wr_prev_r <= 1'b0;
			wa_prev_r <= 16'h0000;
			rd_out_r  <= 1'b0;
		end else begin
			if (mem_req_valid && mem_req_ready) begin
				wr_prev_r <= mem_req.write;
				wa_prev_r <= mem_req.addr;
			end
			if (mem_req_valid && mem_req_ready && !mem_req.write) begin
				rd_out_r <= 1'b1;
			end else if (mem_rsp_valid) begin
				rd_out_r <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	reset_values_a: assert property ($fell(rst) |-> !mem_req_valid && !retire && regs.sp == 16'hffff && regs.pc == 16'h0000)
		else $error("state after reset wrong");
	req_hold_a: assert property (mem_req_valid && !mem_req_ready |=> mem_req_valid && $stable(mem_req))
		else $error("request changed before taken");
	retire_pulse_a: assert property (retire |=> !retire)
		else $error("retire longer than one cycle");
	one_read_a: assert property (mem_req_valid && mem_req_ready && !mem_req.write |-> !rd_out_r || mem_rsp_valid)
		else $error("second read while one open");
	push_order_a: assert property (mem_req_valid && mem_req_ready && mem_req.write && wr_prev_r |->
		mem_req.addr == wa_prev_r - 16'h0001) else $error("push bytes out of order");
	acc_swap_a: assert property ($changed(regs.af_alt) |-> regs.af == $past(regs.af_alt) &&
		regs.af_alt == $past(regs.af) && $stable(regs.hl_alt) && $stable(regs.bc_alt)) else $error("acc swap wrong");
	gen_swap_a: assert property (($changed(regs.bc_alt) || $changed(regs.de_alt) || $changed(regs.hl_alt)) |->
		regs.bc == $past(regs.bc_alt) && regs.de == $past(regs.de_alt) && regs.hl == $past(regs.hl_alt)
		&& regs.hl_alt == $past(regs.hl)) else $error("bank swap wrong");
	swap_short_a: assert property (($changed(regs.af_alt) || $changed(regs.hl_alt)) |->
		retire && regs.pc == $past(regs.pc) + 16'h0001) else $error("swap not one byte");
endmodule
bind ldx_core ldx_core_chk ldx_core_chk_i (.core_clk(core_clk), .rst(rst), .mem_req_valid(mem_req_valid),
	.mem_req(mem_req), .mem_req_ready(mem_req_ready), .mem_rsp_valid(mem_rsp_valid),
	.mem_rsp_data(mem_rsp_data), .regs(regs), .retire(retire));
`default_nettype wire

/* tb/ldx_mem_model.sv */
// Memory partner holding code, stack and data; reads answered next cycle or later
`timescale 1ns/1ps
`default_nettype none
module ldx_mem_model
	import ldx_pkg::*;
(
	// Clock and reset
	input wire logic         core_clk,
	input wire logic         rst,
	// Request side
	input wire logic         mem_req_valid,
	input wire ldx_mem_req_t mem_req,
	input wire logic         mem_req_ready,
	input wire logic [1:0]   dly,
	// Read answer
	output var logic         mem_rsp_valid,
	output var logic [7:0]   mem_rsp_data
);
	logic [7:0]  store [0:65535]; // Whole address space
	logic        pend_r;          // Slow read waiting
	logic [1:0]  cnt_r;           // Cycles left
	logic [15:0] raddr_r;         // Its address

	// Writes land at once; reads answer next cycle or after dly more
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			mem_rsp_valid <= 1'b0;
			mem_rsp_data  <= 8'h00;
			pend_r        <= 1'b0;
		end else begin
			// Idle data toggles so stale bytes never pass
			mem_rsp_valid <= 1'b0;
			mem_rsp_data  <= ~mem_rsp_data;
			if (mem_req_valid && mem_req_ready && mem_req.write) begin
				store[mem_req.addr] <= mem_req.wdata;
			end else if (mem_req_valid && mem_req_ready && dly == 2'h0) begin
				mem_rsp_valid <= 1'b1;
				mem_rsp_data  <= store[mem_req.addr];
			end else if (mem_req_valid && mem_req_ready) begin
				pend_r  <= 1'b1;
				cnt_r   <= dly;
				raddr_r <= mem_req.addr;
			end
			// Slow answer
			if (pend_r && cnt_r == 2'h1) begin
				pend_r        <= 1'b0;
				mem_rsp_valid <= 1'b1;
				mem_rsp_data  <= store[raddr_r];
			end else if (pend_r) begin
				cnt_r <= cnt_r - 2'h1;
			end
		end
	end
endmodule
`default_nettype wire

/* tb/load_exchange_block_transfer_tb_top.sv */
// Testbench: program run checked against a reference executor
`timescale 1ns/1ps
`default_nettype none
module load_exchange_block_transfer_tb_top
	import ldx_pkg::*;
;
	logic         core_clk, rst, mem_req_valid, mem_req_ready, mem_rsp_valid, retire;
	ldx_mem_req_t mem_req;
	logic [7:0]   mem_rsp_data;
	logic [1:0]   dly;
	ldx_regs_t    regs, rr;
	logic [31:0]  lf, fs;
	logic [7:0]   rm [0:65535];
	int           err_total, n_checks, k;
	// Loads, push/pop, swaps, block moves incl. count 1, count 0, overlap, wrap
	logic [7:0]   prog [$] = '{8'h11, 8'h59, 8'h06, 8'h01, 8'h34, 8'h12, 8'h21, 8'hcd, 8'hab, 8'h31, 8'h00, 8'h80,
		8'hc5, 8'hd5, 8'he5, 8'hf5, 8'hc1, 8'hd1, 8'he1, 8'hf1, 8'h08, 8'hd9, 8'h08, 8'h00,
		8'h21, 8'h00, 8'h10, 8'h11, 8'h00, 8'h20, 8'h01, 8'h05, 8'h00, 8'hed, 8'hb0,
		8'h01, 8'h01, 8'h00, 8'hed, 8'hb0, 8'hed, 8'ha0,
		8'h21, 8'hff, 8'h10, 8'h11, 8'hff, 8'h30, 8'h01, 8'h03, 8'h00, 8'hed, 8'hb8, 8'hed, 8'ha8,
		8'h21, 8'h00, 8'h40, 8'h11, 8'h01, 8'h40, 8'h01, 8'h04, 8'h00, 8'hed, 8'hb0,
		8'h21, 8'hff, 8'hff, 8'h11, 8'h00, 8'h50, 8'h01, 8'h02, 8'h00, 8'hed, 8'hb0, 8'hd9, 8'hed, 8'hff};

	ldx_core ldx_core_i (.core_clk(core_clk), .rst(rst), .mem_req_valid(mem_req_valid), .mem_req(mem_req),
		.mem_req_ready(mem_req_ready), .mem_rsp_valid(mem_rsp_valid), .mem_rsp_data(mem_rsp_data),
		.regs(regs), .retire(retire));
	ldx_mem_model ldx_mem_model_i (.core_clk(core_clk), .rst(rst), .mem_req_valid(mem_req_valid),
		.mem_req(mem_req), .mem_req_ready(mem_req_ready), .dly(dly), .mem_rsp_valid(mem_rsp_valid),
		.mem_rsp_data(mem_rsp_data));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [15:0] get_pair(input logic [1:0] c);
		return c == 2'h0 ? rr.bc : c == 2'h1 ? rr.de : c == 2'h2 ? rr.hl : rr.af;
	endfunction
	task automatic set_pair(input logic [1:0] c, input logic [15:0] v, input bit last_af);
		if (c == 2'h0) rr.bc = v;
		else if (c == 2'h1) rr.de = v;
		else if (c == 2'h2) rr.hl = v;
		else if (last_af) rr.af = v;
		else rr.sp = v;
	endtask
	task automatic check(input string what, input logic [159:0] seen, input logic [159:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic stop_test();
		$display("TB: checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// Reference executor: one instruction on rr and rm
	task automatic ref_step();
		logic [7:0]  op, x;
		logic [15:0] d;
		op = rm[rr.pc];
		rr.pc++;
		d = {rm[rr.pc + 16'h0001], rm[rr.pc]};
		if (op == OP_SWAP_ACC_FLAG) {rr.af, rr.af_alt} = {rr.af_alt, rr.af};
		else if (op == OP_SWAP_GENERAL) {rr.bc, rr.de, rr.hl, rr.bc_alt, rr.de_alt, rr.hl_alt} =
			{rr.bc_alt, rr.de_alt, rr.hl_alt, rr.bc, rr.de, rr.hl};
		else if ((op & OP_LOAD_PAIR_M) == OP_LOAD_PAIR_V) begin
			rr.pc += 16'h0002;
			set_pair(op[5:4], d, 1'b0);
		end else if ((op & OP_PUSH_M) == OP_PUSH_V) begin
			d = get_pair(op[5:4]);
			rr.sp--;
			rm[rr.sp] = d[15:8];
			rr.sp--;
			rm[rr.sp] = d[7:0];
		end else if ((op & OP_POP_M) == OP_POP_V) begin
			d = {rm[rr.sp + 16'h0001], rm[rr.sp]};
			rr.sp += 16'h0002;
			set_pair(op[5:4], d, 1'b1);
		end else if (op == OP_PREFIX_EXT) begin
			x = rm[rr.pc];
			rr.pc++;
			if (x inside {OP_MOVE_UP_ONCE, OP_MOVE_UP_RPT, OP_MOVE_DN_ONCE, OP_MOVE_DN_RPT}) begin
				do begin
					rm[rr.de] = rm[rr.hl];
					rr.hl = x[3] ? rr.hl - 16'h0001 : rr.hl + 16'h0001;
					rr.de = x[3] ? rr.de - 16'h0001 : rr.de + 16'h0001;
					rr.bc--;
				end while (x[4] && rr.bc != 16'h0000);
			end
		end
	endtask

	// Clock
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	// Random ready stalls and answer delays
	always @(posedge core_clk) begin
		lf            <= lfsr(lf);
		mem_req_ready <= lf[2:0] != 3'h0;
		dly           <= lf[5:4];
	end
	// Watchdog
	initial begin
		repeat (40000) @(posedge core_clk);
		err_total++;
		stop_test();
	end
	// Main sequence
	initial begin
		rst = 1'b1;
		mem_req_ready = 1'b0;
		dly = 2'h0;
		lf = 32'h2ba1;
		fs = 32'h2ba1;
		err_total = 0;
		n_checks = 0;
		rr = '{sp: RST_SP, default: RST_PAIR};
		for (int i = 0; i < 65536; i++) begin
			fs = lfsr(fs);
			rm[i] = i < prog.size() ? prog[i] : fs[7:0];
			ldx_mem_model_i.store[i] = rm[i];
		end
		repeat (6) @(posedge core_clk);
		rst <= 1'b0;
		check("reset regs", regs, rr);
		while (int'(rr.pc) < prog.size()) begin
			k = 0;
			do begin
				@(posedge core_clk);
				#1;
				k++;
			end while (retire !== 1'b1 && k < 3000);
			ref_step();
			check("regs", regs, rr);
		end
		// Let queued writes drain ahead of the next fetch
		k = 0;
		do begin
			@(posedge core_clk);
			k++;
		end while (!(mem_req_valid && mem_req_ready && !mem_req.write) && k < 200);
		#1;
		for (int a = 0; a < 65536; a++) check("mem", ldx_mem_model_i.store[a], rm[a]);
		stop_test();
	end
endmodule
`default_nettype wire
